// ### include/fawp_pkg.sv
package fawp_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W          = 24;
    localparam int ARRAY_BYTES     = 16777216;
    localparam int SECTOR_COUNT    = 256;
    localparam int SUBSECTOR_COUNT = 4096;
    localparam int PAGE_COUNT      = 65536;
    localparam int PAGE_BYTES      = 256;
    localparam int SUBSECTOR_BYTES = 4096;
    localparam int SECTOR_BYTES    = 65536;
    localparam int OTP_BYTES       = 64;
    localparam int SECTOR_LSB      = 16;
    localparam int SECTOR_W        = 8;
    localparam int BITS_PER_BYTE   = 8;

    // ------------------------------------------------------------
    // Protection decode and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] BP_ALL_CODE = 4'h9;
    localparam logic [3:0] BP_RST      = 4'h0;
    localparam logic       SIDE_RST    = 1'b0;
    localparam logic [SECTOR_COUNT-1:0] WLOCK_RST = {SECTOR_COUNT{1'b1}};
    localparam logic [SECTOR_COUNT-1:0] LDOWN_RST = {SECTOR_COUNT{1'b0}};

    // Command data field positions
    localparam int LOCK_WR_BIT   = 0;
    localparam int LOCK_DN_BIT   = 1;
    localparam int STAT_SIDE_BIT = 4;

    // Synchronised pin positions
    localparam int PIN_LCLK = 0;
    localparam int PIN_SELN = 1;
    localparam int PIN_WPN  = 2;
    localparam int PIN_PWR  = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int PWR_SETTLE_NS  = 1000;
    localparam int PWR_SETTLE_CYC = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE, OP_WREN, OP_WRDI, OP_PAGE_PROG, OP_SUB_ERASE,
        OP_SEC_ERASE, OP_BULK_ERASE, OP_OTP_PROG, OP_LOCK_WR, OP_STAT_WR
    } fawp_op_t;

    typedef enum logic [2:0] {
        RC_NONE, RC_COUNT, RC_WEL, RC_POWER, RC_LOCKED, RC_RANGE, RC_BADOP
    } fawp_cause_t;

    typedef enum logic [1:0] {ST_POWERUP, ST_IDLE, ST_FRAME} fawp_st_t;

    typedef struct packed {
        fawp_op_t          op;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } fawp_cmd_t;

    typedef struct packed {
        logic              go;
        logic              refuse;
        fawp_cause_t       cause;
        fawp_op_t          kind;
        logic [ADDR_W-1:0] first;
        logic [ADDR_W-1:0] last;
        logic [7:0]        wr_byte;
    } fawp_res_t;

    typedef struct packed {
        fawp_st_t          state;
        logic [3:0]        sync1;
        logic [3:0]        sync2;
        logic              lclk_d;
        logic [15:0]       pwr_cnt;
        logic [2:0]        bitcnt;
        logic              pend;
        fawp_cmd_t         cmd;
        logic              wel;
        logic [3:0]        bp;
        logic              side;
        logic [SECTOR_COUNT-1:0] wlock;
        logic [SECTOR_COUNT-1:0] ldown;
        fawp_res_t         res;
    } fawp_state_t;

    // Sector index of a byte address
    function automatic logic [SECTOR_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
        return a[SECTOR_LSB +: SECTOR_W];
    endfunction : sector_of

    // Commands that change array or register contents
    function automatic logic is_modify(input fawp_op_t op);
        return !(op == OP_NONE || op == OP_WREN || op == OP_WRDI);
    endfunction : is_modify

endpackage : fawp_pkg

// ### design/fawp_region_decode.sv
`timescale 1ns/1ps
module fawp_region_decode
    import fawp_pkg::*;
(
    // Protection code
    input  wire logic [3:0]          code,
    input  wire logic                side,
    // Sector under test
    input  wire logic [SECTOR_W-1:0] sector,
    // Decode result
    output logic                     hit,
    output logic                     any
);

    logic [8:0] span;

    // ------------------------------------------------------------
    // Protected sector count, then compare at the chosen end
    // ------------------------------------------------------------
    always_comb begin
        if (code == 4'h0) begin
            span = 9'h000;
        end else if (code >= BP_ALL_CODE) begin
            span = 9'h100;
        end else begin
            span = 9'h001 << (code - 4'h1);
        end
        any = (span != 9'h000);
        if (side) begin
            hit = ({1'b0, sector} < span);
        end else begin
            hit = ({1'b0, sector} >= (9'h100 - span));
        end
    end

endmodule : fawp_region_decode

// ### design/fawp_guard.sv
`timescale 1ns/1ps
module fawp_guard
    import fawp_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Link pins, asynchronous
    input  wire logic        link_clk,
    input  wire logic        link_sel_n,
    input  wire logic        write_prot_n,
    input  wire logic        supply_ok,
    // Protection pin usage select
    input  wire logic        wp_pin_en,
    // Decoded command from the serial front end
    input  wire logic        cmd_valid,
    input  wire fawp_cmd_t   cmd_in,
    input  wire logic [7:0]  array_old_byte,
    // Operation result
    output fawp_res_t        op_out,
    // Status
    output logic             write_latch,
    output logic             protect_level_bit0,
    output logic             protect_level_bit1,
    output logic             protect_level_bit2,
    output logic             protect_level_bit3,
    output logic             protect_region_side
);

    fawp_state_t s_q;
    fawp_state_t nxt_s;
    logic                bp_hit;
    logic                bp_any;
    logic [SECTOR_W-1:0] cur_sec;
    logic                link_rise;
    logic                wp_active;
    logic                sec_prot;
    fawp_cause_t         cause;

    // ------------------------------------------------------------
    // Block-protect region decode
    // ------------------------------------------------------------
    assign cur_sec = sector_of(s_q.cmd.addr);

    fawp_region_decode u_region (
        .code   (s_q.bp),
        .side   (s_q.side),
        .sector (cur_sec),
        .hit    (bp_hit),
        .any    (bp_any)
    );

    // Synchronised pin views
    assign link_rise = s_q.sync2[PIN_LCLK] & ~s_q.lclk_d;
    assign wp_active = wp_pin_en & ~s_q.sync2[PIN_WPN];
    assign sec_prot  = s_q.wlock[cur_sec] | bp_hit;

    // ------------------------------------------------------------
    // Command checks
    // ------------------------------------------------------------
    always_comb begin
        cause = RC_NONE;
        if (s_q.bitcnt != 3'h0) begin
            cause = RC_COUNT;
        end else if (is_modify(s_q.cmd.op) && !s_q.wel) begin
            cause = RC_WEL;
        end else begin
            case (s_q.cmd.op)
                OP_WREN, OP_WRDI: cause = RC_NONE;
                OP_PAGE_PROG, OP_SUB_ERASE, OP_SEC_ERASE: begin
                    if (sec_prot) cause = RC_LOCKED;
                end
                OP_BULK_ERASE: begin
                    if ((|s_q.wlock) || bp_any) cause = RC_LOCKED;
                end
                OP_OTP_PROG: begin
                    if (s_q.cmd.addr >= ADDR_W'(OTP_BYTES)) cause = RC_RANGE;
                end
                OP_LOCK_WR: begin
                    if (s_q.ldown[cur_sec]) cause = RC_LOCKED;
                end
                OP_STAT_WR: begin
                    if (wp_active) cause = RC_LOCKED;
                end
                default: cause = RC_BADOP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_s            = s_q;
        nxt_s.sync1      = {supply_ok, write_prot_n, link_sel_n, link_clk};
        nxt_s.sync2      = s_q.sync1;
        nxt_s.lclk_d     = s_q.sync2[PIN_LCLK];
        nxt_s.res.go     = 1'b0;
        nxt_s.res.refuse = 1'b0;
        case (s_q.state)
            ST_POWERUP: begin
                nxt_s.wel = 1'b0;
                if (!s_q.sync2[PIN_PWR]) begin
                    nxt_s.pwr_cnt = 16'h0000;
                end else if (s_q.pwr_cnt == 16'(PWR_SETTLE_CYC - 1)) begin
                    nxt_s.state = ST_IDLE;
                end else begin
                    nxt_s.pwr_cnt = s_q.pwr_cnt + 16'h0001;
                end
            end
            ST_IDLE: begin
                if (!s_q.sync2[PIN_PWR]) begin
                    nxt_s.state   = ST_POWERUP;
                    nxt_s.pwr_cnt = 16'h0000;
                end else if (!s_q.sync2[PIN_SELN]) begin
                    nxt_s.state  = ST_FRAME;
                    nxt_s.bitcnt = 3'h0;
                    nxt_s.pend   = 1'b0;
                end
            end
            ST_FRAME: begin
                if (link_rise) nxt_s.bitcnt = s_q.bitcnt + 3'h1;
                if (cmd_valid && !s_q.pend) begin
                    nxt_s.pend = 1'b1;
                    nxt_s.cmd  = cmd_in;
                end
                if (!s_q.sync2[PIN_PWR]) begin
                    nxt_s.state   = ST_POWERUP;
                    nxt_s.pwr_cnt = 16'h0000;
                    if (s_q.pend) begin
                        nxt_s.res.refuse = 1'b1;
                        nxt_s.res.cause  = RC_POWER;
                        nxt_s.res.kind   = s_q.cmd.op;
                    end
                end else if (s_q.sync2[PIN_SELN]) begin
                    nxt_s.state = ST_IDLE;
                    if (s_q.pend) begin
                        nxt_s.res.kind    = s_q.cmd.op;
                        nxt_s.res.cause   = cause;
                        nxt_s.res.first   = s_q.cmd.addr;
                        nxt_s.res.last    = s_q.cmd.addr;
                        nxt_s.res.wr_byte = 8'h00;
                        if (cause != RC_NONE) begin
                            nxt_s.res.refuse = 1'b1;
                        end else begin
                            nxt_s.res.go = 1'b1;
                            if (is_modify(s_q.cmd.op)) nxt_s.wel = 1'b0;
                            case (s_q.cmd.op)
                                OP_WREN: nxt_s.wel = 1'b1;
                                OP_WRDI: nxt_s.wel = 1'b0;
                                OP_PAGE_PROG: begin
                                    nxt_s.res.first = {s_q.cmd.addr[23:8], 8'h00};
                                    nxt_s.res.last  = {s_q.cmd.addr[23:8], 8'hff};
                                    nxt_s.res.wr_byte = array_old_byte & s_q.cmd.data;
                                end
                                OP_OTP_PROG: begin
                                    nxt_s.res.wr_byte = array_old_byte & s_q.cmd.data;
                                end
                                OP_SUB_ERASE: begin
                                    nxt_s.res.first = {s_q.cmd.addr[23:12], 12'h000};
                                    nxt_s.res.last  = {s_q.cmd.addr[23:12], 12'hfff};
                                    nxt_s.res.wr_byte = 8'hff;
                                end
                                OP_SEC_ERASE: begin
                                    nxt_s.res.first = {s_q.cmd.addr[23:16], 16'h0000};
                                    nxt_s.res.last  = {s_q.cmd.addr[23:16], 16'hffff};
                                    nxt_s.res.wr_byte = 8'hff;
                                end
                                OP_BULK_ERASE: begin
                                    nxt_s.res.first = 24'h000000;
                                    nxt_s.res.last  = 24'(ARRAY_BYTES - 1);
                                    nxt_s.res.wr_byte = 8'hff;
                                end
                                OP_LOCK_WR: begin
                                    nxt_s.wlock[cur_sec] = s_q.cmd.data[LOCK_WR_BIT];
                                    nxt_s.ldown[cur_sec] = s_q.cmd.data[LOCK_DN_BIT];
                                end
                                OP_STAT_WR: begin
                                    nxt_s.bp   = s_q.cmd.data[3:0];
                                    nxt_s.side = s_q.cmd.data[STAT_SIDE_BIT];
                                end
                                default: nxt_s.res.wr_byte = 8'h00;
                            endcase
                        end
                    end
                end
            end
            default: nxt_s.state = ST_POWERUP;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q       <= '0;
            s_q.wlock <= WLOCK_RST;
            s_q.ldown <= LDOWN_RST;
            s_q.bp    <= BP_RST;
            s_q.side  <= SIDE_RST;
        end else begin
            s_q <= nxt_s;
        end
    end

    // Outputs
    assign op_out              = s_q.res;
    assign write_latch         = s_q.wel;
    assign protect_level_bit0  = s_q.bp[0];
    assign protect_level_bit1  = s_q.bp[1];
    assign protect_level_bit2  = s_q.bp[2];
    assign protect_level_bit3  = s_q.bp[3];
    assign protect_region_side = s_q.side;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_wel_needed: assert property (@(posedge core_clk) disable iff (rst)
        s_q.res.go && is_modify(s_q.res.kind) |-> $past(s_q.wel) && !s_q.wel)
        else $error("modify executed without write latch");

    chk_whole_bytes: assert property (@(posedge core_clk) disable iff (rst)
        $rose(s_q.res.go) |-> $past(s_q.bitcnt) == 3'h0)
        else $error("command executed on partial byte");

    chk_power_block: assert property (@(posedge core_clk) disable iff (rst)
        s_q.state == ST_POWERUP |=> !s_q.res.go)
        else $error("operation during power settle");

    chk_lock_blocks: assert property (@(posedge core_clk) disable iff (rst)
        s_q.res.go && (s_q.res.kind inside {OP_SUB_ERASE, OP_SEC_ERASE, OP_PAGE_PROG})
        |-> !s_q.wlock[sector_of(s_q.res.first)])
        else $error("locked sector modified");

    chk_ldown_freeze: assert property (@(posedge core_clk) disable iff (rst)
        ((s_q.wlock ^ $past(s_q.wlock)) & $past(s_q.ldown)) == '0)
        else $error("frozen lock bit changed");

    chk_ldown_sticky: assert property (@(posedge core_clk) disable iff (rst)
        ($past(s_q.ldown) & ~s_q.ldown) == '0)
        else $error("lock-down cleared without reset");

    chk_wp_freeze: assert property (@(posedge core_clk) disable iff (rst)
        wp_active |=> $stable(s_q.bp) && $stable(s_q.side))
        else $error("protect bits changed under write-protect");

    chk_erase_ones: assert property (@(posedge core_clk) disable iff (rst)
        s_q.res.go && (s_q.res.kind inside {OP_SUB_ERASE, OP_SEC_ERASE, OP_BULK_ERASE})
        |-> s_q.res.wr_byte == 8'hff)
        else $error("erase data not all ones");

    chk_prog_clears: assert property (@(posedge core_clk) disable iff (rst)
        s_q.res.go && s_q.res.kind == OP_PAGE_PROG
        |-> (s_q.res.wr_byte & ~$past(array_old_byte)) == 8'h00)
        else $error("program set a bit");

    chk_page_span: assert property (@(posedge core_clk) disable iff (rst)
        s_q.res.go && s_q.res.kind == OP_PAGE_PROG
        |-> s_q.res.last - s_q.res.first == 24'(PAGE_BYTES - 1))
        else $error("program span not one page");

endmodule : fawp_guard

// ### test/fawp_host.sv
`timescale 1ns/1ps
module fawp_host
    import fawp_pkg::*;
(
    // Clock
    input  wire logic core_clk,
    // Link pins
    output logic      link_clk,
    output logic      link_sel_n,
    // Decoded command
    output logic      cmd_valid,
    output fawp_cmd_t cmd_in
);
    // ------------------------------------------------------------
    // Idle link: clock parked low, select high
    // ------------------------------------------------------------
    initial begin
        link_clk   = 1'b0;
        link_sel_n = 1'b1;
        cmd_valid  = 1'b0;
        cmd_in     = '0;
    end

    // One frame of n rising link edges, lag extra idle cycles before clocking
    task automatic frame(input fawp_cmd_t c, input int n, input int lag);
        @(negedge core_clk) link_sel_n = 1'b0;
        repeat (4 + lag) @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_in    = c;
        repeat (n) begin
            repeat (4) @(negedge core_clk);
            link_clk = 1'b1;
            repeat (4) @(negedge core_clk);
            link_clk = 1'b0;
        end
        repeat (2) @(negedge core_clk);
        link_sel_n = 1'b1;
        cmd_valid  = 1'b0;
        cmd_in     = ~c; // Released bus shows no stale value
    endtask : frame
endmodule : fawp_host

// ### test/tb_fawp_guard.sv
`timescale 1ns/1ps
module tb_fawp_guard;
    import fawp_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst, link_clk, link_sel_n, write_prot_n, supply_ok, wp_pin_en, cmd_valid;
    logic       write_latch, protect_region_side;
    logic       protect_level_bit0, protect_level_bit1, protect_level_bit2, protect_level_bit3;
    logic [7:0] array_old_byte;
    fawp_cmd_t  cmd_in;
    fawp_res_t  op_out;
    logic [7:0] secs [8] = '{8'd0, 8'd1, 8'd63, 8'd64, 8'd127, 8'd128, 8'd254, 8'd255};
    int         num_errors = 0;
    int         total_checks = 0;
    int         s, c;

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    fawp_guard fawp_guard_i (.core_clk, .rst, .link_clk, .link_sel_n, .write_prot_n, .supply_ok,
        .wp_pin_en, .cmd_valid, .cmd_in, .array_old_byte, .op_out, .write_latch,
        .protect_level_bit0, .protect_level_bit1, .protect_level_bit2, .protect_level_bit3,
        .protect_region_side);

    fawp_host fawp_host_i (.core_clk, .link_clk, .link_sel_n, .cmd_valid, .cmd_in);

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic conclude;
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // Expected protection of a sector under a level code and side
    function automatic logic prot(input logic [3:0] code, input logic side, input int sec);
        int n;
        n = (code == 4'h0) ? 0 : (code >= 4'h9) ? 256 : (1 << (code - 1));
        return side ? (sec < n) : (sec >= 256 - n);
    endfunction : prot

    // One frame and the answer to it
    task automatic run(input fawp_op_t op, input logic [23:0] a, input logic [7:0] d,
                       input int n, input logic ok, input fawp_cause_t why);
        logic [23:0] m;
        logic [7:0]  old;
        logic        wl;
        int          k;
        @(negedge core_clk) array_old_byte = 8'($urandom);
        old = array_old_byte;
        wl  = write_latch;
        fawp_host_i.frame('{op, a, d}, n, $urandom % 3);
        for (k = 0; k < 12 && (op_out.go | op_out.refuse) !== 1'b1; k++)
            @(posedge core_clk) #1;
        check_val(op_out.go, ok);
        check_val(op_out.refuse, !ok && why != RC_POWER);
        check_val(op_out.kind, op);
        check_val(write_latch, (why == RC_POWER) ? 1'b0 :
            (op == OP_WREN && ok) ? 1'b1 : ok ? 1'b0 : wl);
        if (!ok)
            check_val(op_out.cause, why);
        if (ok && op inside {OP_PAGE_PROG, OP_SUB_ERASE, OP_SEC_ERASE, OP_BULK_ERASE}) begin
            m = (op == OP_PAGE_PROG) ? 24'h0000ff : (op == OP_SUB_ERASE) ? 24'h000fff :
                (op == OP_SEC_ERASE) ? 24'h00ffff : 24'hffffff;
            check_val(op_out.first, a & ~m);
            check_val(op_out.last, a | m);
        end
        if (ok)
            check_val(op_out.wr_byte, (op inside {OP_PAGE_PROG, OP_OTP_PROG}) ? (old & d) :
                (op inside {OP_SUB_ERASE, OP_SEC_ERASE, OP_BULK_ERASE}) ? 8'hff : 8'h00);
    endtask : run

    // Enable writes, then the command
    task automatic wr(input fawp_op_t op, input logic [23:0] a, input logic [7:0] d,
                      input logic ok, input fawp_cause_t why);
        run(OP_WREN, 24'h0, 8'h00, 8, 1'b1, RC_NONE);
        run(op, a, d, 8, ok, why);
    endtask : wr

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(24));
        rst            = 1'b1;
        write_prot_n   = 1'b1;
        supply_ok      = 1'b1;
        wp_pin_en      = 1'b0;
        array_old_byte = 8'h00;
        repeat (5) @(negedge core_clk);
        check_val({op_out.go, op_out.refuse, op_out.cause, op_out.kind, write_latch,
            protect_region_side, protect_level_bit3, protect_level_bit0}, 32'h0);
        rst = 1'b0;
        repeat (120) @(negedge core_clk);
        run(OP_WREN, 24'h0, 8'h00, 7, 1'b0, RC_COUNT);
        run(OP_SEC_ERASE, 24'h010000, 8'h00, 8, 1'b0, RC_WEL);
        wr(OP_SEC_ERASE, 24'h010000, 8'h00, 1'b0, RC_LOCKED);
        wr(OP_BULK_ERASE, 24'h0, 8'h00, 1'b0, RC_LOCKED);
        foreach (secs[i])
            wr(OP_LOCK_WR, {secs[i], 16'h0}, 8'h00, 1'b1, RC_NONE);
        wr(OP_SUB_ERASE, {secs[4], 16'h3a12}, 8'h00, 1'b1, RC_NONE);
        wr(OP_SEC_ERASE, {secs[7], 16'h8001}, 8'h00, 1'b1, RC_NONE);
        wr(OP_OTP_PROG, 24'd63, 8'h5a, 1'b1, RC_NONE);
        wr(OP_OTP_PROG, 24'd64, 8'h5a, 1'b0, RC_RANGE);
        wr(OP_NONE, 24'h0, 8'h00, 1'b0, RC_BADOP);
        wr(OP_WRDI, 24'h0, 8'h00, 1'b1, RC_NONE);
        run(OP_PAGE_PROG, 24'h0, 8'h00, 8, 1'b0, RC_WEL);
        repeat (6)
            wr(OP_PAGE_PROG, {secs[$urandom % 8], 16'($urandom)}, 8'($urandom), 1'b1, RC_NONE);
        // Every level code on both sides, boundary sectors
        for (s = 0; s < 2; s++)
            for (c = 0; c < 16; c++) begin
                wr(OP_STAT_WR, 24'h0, {3'h0, s[0], c[3:0]}, 1'b1, RC_NONE);
                check_val({protect_region_side, protect_level_bit3, protect_level_bit2,
                    protect_level_bit1, protect_level_bit0}, {s[0], c[3:0]});
                foreach (secs[i])
                    wr(OP_SEC_ERASE, {secs[i], 16'h0}, 8'h00, !prot(c[3:0], s[0], secs[i]),
                        RC_LOCKED);
            end
        // Protect pin freezes the level code
        @(negedge core_clk) wp_pin_en = 1'b1;
        write_prot_n = 1'b0;
        wr(OP_STAT_WR, 24'h0, 8'h05, 1'b0, RC_LOCKED);
        @(negedge core_clk) write_prot_n = 1'b1;
        wr(OP_STAT_WR, 24'h0, 8'h00, 1'b1, RC_NONE);
        // Lock-down freezes a sector
        wr(OP_LOCK_WR, {secs[1], 16'h0}, 8'h03, 1'b1, RC_NONE);
        wr(OP_LOCK_WR, {secs[1], 16'h0}, 8'h00, 1'b0, RC_LOCKED);
        wr(OP_LOCK_WR, {secs[0], 16'h0}, 8'h02, 1'b1, RC_NONE);
        wr(OP_SEC_ERASE, 24'h0, 8'h00, 1'b1, RC_NONE);
        wr(OP_LOCK_WR, 24'h0, 8'h01, 1'b0, RC_LOCKED);
        // Supply drop during a frame
        fork
            run(OP_WREN, 24'h0, 8'h00, 8, 1'b0, RC_POWER);
            begin
                repeat (30) @(negedge core_clk);
                supply_ok = 1'b0;
                // Refusal pulse lands three edges after the drop
                repeat (3) @(posedge core_clk);
                #1 check_val(op_out.refuse, 1'b1);
            end
        join
        @(negedge core_clk) supply_ok = 1'b1;
        // Second reset restores locks and clears lock-down
        rst = 1'b1;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        repeat (120) @(negedge core_clk);
        wr(OP_SEC_ERASE, 24'h0, 8'h00, 1'b0, RC_LOCKED);
        wr(OP_LOCK_WR, {secs[1], 16'h0}, 8'h00, 1'b1, RC_NONE);
        conclude();
    end

    // Watchdog at 90k cycles, well beyond the roughly 50k the tests need
    initial begin
        #900000;
        num_errors++;
        conclude();
    end
endmodule : tb_fawp_guard
